// *** ecc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecc_top (
   input  wire logic                 sys_clk,        // 40 MHz system clock
   input  wire logic                 srst,           // Sync reset, high
   input  wire ecc_pkg::ecc_apb_req_t apb_req,       // APB request group
   output var  logic [31:0]          prdata,         // APB read data
   output logic                      pready,         // APB ready
   output logic                      pslverr,        // APB error
   input  wire logic                 high_event_pin, // Async high event
   input  wire logic                 low_event_pin,  // Async low event
   input  wire logic                 external_count_gate, // Async gate
   input  wire logic                 pwm_count_gate, // PWM gate, same clock
   output var  logic                 pwm_clock_tick, // Prescaled PWM tick
   output logic                      irq             // Level interrupt
);
   import ecc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   ecc_clk_ctrl_t          clkctl_q;
   ecc_csr_t               csr_q;
   logic [7:0]             high_q;
   logic [7:0]             low_q;
   logic [1:0]             istat_q;
   logic [1:0]             imask_q;
   logic                   armed_h_q;
   logic                   armed_l_q;
   logic [ECC_PRESC_W-1:0] div_q;
   logic [ECC_PRESC_W-1:0] div_tick;
   logic [31:0]            prdata_q;
   logic [2:0]             hpin_q;
   logic [2:0]             lpin_q;
   logic [1:0]             gate_q;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic       setup;
   logic       ack;
   logic       hit;
   logic       wr;
   logic       rd;
   logic [7:0] addr;

   assign addr  = apb_req.paddr;
   assign setup = apb_req.psel & ~apb_req.penable;
   assign ack   = apb_req.psel & apb_req.penable;
   assign hit   = (addr == ECC_ADDR_CLKCTL) | (addr == ECC_ADDR_CSR)
                | (addr == ECC_ADDR_COUNT) | (addr == ECC_ADDR_ISTAT)
                | (addr == ECC_ADDR_IMASK);
   assign wr    = ack & apb_req.pwrite & hit;
   assign rd    = ack & ~apb_req.pwrite & hit;

   // Read data is latched in setup so the bus sees a flop, no wait state
   assign pready  = 1'b1;
   assign pslverr = ack & ~hit;
   assign prdata  = prdata_q;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Stage 0 is only read by stage 1; stage 2 is kept for edges
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         hpin_q <= 3'h0;
         lpin_q <= 3'h0;
         gate_q <= 2'h0;
      end else begin
         hpin_q <= {hpin_q[1:0], high_event_pin};
         lpin_q <= {lpin_q[1:0], low_event_pin};
         gate_q <= {gate_q[0], external_count_gate};
      end
   end

   logic high_edge;
   logic low_edge;
   logic gate_ok;

   // Rising edges only; there is no edge select
   assign high_edge = hpin_q[1] & ~hpin_q[2];
   assign low_edge  = lpin_q[1] & ~lpin_q[2];
   assign gate_ok   = gate_q[1] | pwm_count_gate;

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Tap n pulses once every 2^(n+1) clocks
   generate
      for (genvar n = 0; n < ECC_PRESC_W; n++) begin : g_tap
         assign div_tick[n] = &div_q[n:0];
      end
   endgenerate

   // Taps come in as an argument so the continuous assigns re-evaluate on them
   function automatic logic pick(input logic [1:0] code,
                                 input logic       pin,
                                 input logic [2:0] taps);
      logic r;
      r = 1'b0;
      unique case (code)
         ECC_SEL_PIN:  r = pin;
         ECC_SEL_DIV2: r = taps[0];
         ECC_SEL_DIV4: r = taps[1];
         ECC_SEL_DIV8: r = taps[2];
      endcase
      return r;
   endfunction

   logic high_tick;
   logic low_tick;
   logic pwm_tick;

   assign high_tick = pick(clkctl_q.high_clock_select, high_edge, div_tick[2:0]);
   assign low_tick  = pick(clkctl_q.low_clock_select, low_edge, div_tick[2:0]);

   // Middle bit is ignored in the two slowest codes
   always_comb begin
      if (clkctl_q.pwm_prescale[2]) begin
         pwm_tick = clkctl_q.pwm_prescale[0] ? div_tick[5] : div_tick[4];
      end else begin
         pwm_tick = div_tick[clkctl_q.pwm_prescale[1:0]];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pwm_clock_tick <= 1'b0;
      end else begin
         pwm_clock_tick <= pwm_tick;
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   logic split;
   logic low_inc;
   logic low_wrap;
   logic high_src;
   logic high_inc;
   logic ovh_set;
   logic ovl_set;

   assign split    = csr_q.channel_split_mode;
   assign low_inc  = low_tick & gate_ok & csr_q.low_count_enable
                   & csr_q.low_reset_release;
   assign low_wrap = low_inc & (low_q == ECC_CNT_MAX);
   assign high_src = split ? (high_tick & gate_ok) : low_wrap;
   assign high_inc = high_src & csr_q.high_count_enable
                   & csr_q.high_reset_release;
   assign ovh_set  = high_inc & (high_q == ECC_CNT_MAX);
   assign ovl_set  = low_wrap & split;

   always_ff @(posedge sys_clk) begin
      if (srst || !csr_q.low_reset_release) begin
         low_q <= ECC_CNT_ZERO;
      end else if (low_inc) begin
         low_q <= low_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || !csr_q.high_reset_release) begin
         high_q <= ECC_CNT_ZERO;
      end else if (high_inc) begin
         high_q <= high_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         clkctl_q <= ECC_REG_RESET;
      end else if (wr && addr == ECC_ADDR_CLKCTL) begin
         clkctl_q <= apb_req.pwdata[7:0];
      end
   end

   logic csr_wr;
   logic csr_rd;

   assign csr_wr = wr & (addr == ECC_ADDR_CSR);
   assign csr_rd = rd & (addr == ECC_ADDR_CSR);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         csr_q <= ECC_REG_RESET;
      end else begin
         if (csr_wr) begin
            csr_q[ECC_RSVD_CSR:0] <= apb_req.pwdata[ECC_RSVD_CSR:0];
         end
         // A set in the same cycle beats the clear; a one written by software is never stored
         if (ovh_set) begin
            csr_q.high_overflow_flag <= 1'b1;
         end else if (csr_wr && !apb_req.pwdata[ECC_FLAG_HIGH] && armed_h_q) begin
            csr_q.high_overflow_flag <= 1'b0;
         end
         if (ovl_set) begin
            csr_q.low_overflow_flag <= 1'b1;
         end else if (csr_wr && !apb_req.pwdata[ECC_FLAG_LOW] && armed_l_q) begin
            csr_q.low_overflow_flag <= 1'b0;
         end
      end
   end

   // Arming remembers that software saw the flag at one
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         armed_h_q <= 1'b0;
         armed_l_q <= 1'b0;
      end else begin
         if (csr_wr && !apb_req.pwdata[ECC_FLAG_HIGH]) begin
            armed_h_q <= 1'b0;
         end else if (csr_rd && prdata_q[ECC_FLAG_HIGH]) begin
            armed_h_q <= 1'b1;
         end
         if (csr_wr && !apb_req.pwdata[ECC_FLAG_LOW]) begin
            armed_l_q <= 1'b0;
         end else if (csr_rd && prdata_q[ECC_FLAG_LOW]) begin
            armed_l_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   logic [1:0] ev;
   logic [1:0] w1c;

   assign ev  = {ovl_set, ovh_set};
   assign w1c = (wr && addr == ECC_ADDR_ISTAT) ? apb_req.pwdata[1:0] : 2'h0;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         istat_q <= ECC_IRQ_RESET;
         imask_q <= ECC_IRQ_RESET;
      end else begin
         istat_q <= (istat_q & ~w1c) | ev;
         if (wr && addr == ECC_ADDR_IMASK) begin
            imask_q <= apb_req.pwdata[1:0];
         end
      end
   end

   assign irq = |(istat_q & imask_q);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata_q <= '0;
      end else if (setup) begin
         prdata_q <= '0;
         unique case (addr)
            ECC_ADDR_CLKCTL: prdata_q[7:0]  <= clkctl_q;
            ECC_ADDR_CSR:    prdata_q[7:0]  <= csr_q;
            ECC_ADDR_COUNT:  prdata_q[15:0] <= {high_q, low_q};
            ECC_ADDR_ISTAT:  prdata_q[1:0]  <= istat_q;
            ECC_ADDR_IMASK:  prdata_q[1:0]  <= imask_q;
            default:         prdata_q       <= '0;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic h_on;
   assign h_on = split & gate_ok & csr_q.high_count_enable
               & csr_q.high_reset_release;

   high_div8_a: assert property (
      h_on && clkctl_q.high_clock_select == ECC_SEL_DIV8
      |-> high_inc == (&div_q[2:0]))
      else $error("high div8 select wrong");

   high_div2_a: assert property (
      h_on && clkctl_q.high_clock_select == ECC_SEL_DIV2
      |-> high_inc == div_q[0])
      else $error("high div2 select wrong");

   low_pin_a: assert property (
      gate_ok && csr_q.low_count_enable && csr_q.low_reset_release
      && clkctl_q.low_clock_select == ECC_SEL_PIN |-> low_inc == low_edge)
      else $error("low pin select wrong");

   pwm_div64_a: assert property (
      clkctl_q.pwm_prescale[2] && clkctl_q.pwm_prescale[0]
      |=> pwm_clock_tick == $past(&div_q))
      else $error("pwm div64 tick wrong");

   rsvd_bit_a: assert property (
      csr_wr |=> csr_q.reserved == $past(apb_req.pwdata[ECC_RSVD_CSR]))
      else $error("reserved bit not stored");

   high_ovf_a: assert property (
      ovh_set |=> csr_q.high_overflow_flag && high_q == ECC_CNT_ZERO)
      else $error("high overflow not flagged");

   low_ovf_a: assert property (
      $rose(csr_q.low_overflow_flag) |-> $past(split && low_wrap))
      else $error("low flag set outside split wrap");

   flag_clear_a: assert property (
      $fell(csr_q.high_overflow_flag)
      |-> $past(csr_wr && armed_h_q && !apb_req.pwdata[ECC_FLAG_HIGH]))
      else $error("high flag cleared without read-write sequence");

   no_sw_set_a: assert property (
      $rose(csr_q.high_overflow_flag) |-> $past(ovh_set))
      else $error("high flag set by software");

   chain_step_a: assert property (
      !split && low_wrap && csr_q.high_count_enable
      && csr_q.high_reset_release && !csr_wr
      |=> high_q == $past(high_q) + 8'h01)
      else $error("chain carry lost");

   high_hold_a: assert property (
      !csr_q.high_count_enable && csr_q.high_reset_release && !csr_wr
      |=> $stable(high_q))
      else $error("high counter moved while disabled");

   low_hold_a: assert property (
      !csr_q.low_count_enable && csr_q.low_reset_release && !csr_wr
      |=> $stable(low_q))
      else $error("low counter moved while disabled");

   high_rst_a: assert property (
      !csr_q.high_reset_release |=> high_q == ECC_CNT_ZERO)
      else $error("high counter not held in reset");

   low_rst_a: assert property (
      !csr_q.low_reset_release |=> low_q == ECC_CNT_ZERO)
      else $error("low counter not held in reset");

   reg_reset_a: assert property (@(posedge sys_clk) disable iff (1'b0)
      srst |=> clkctl_q == ECC_REG_RESET && csr_q == ECC_REG_RESET)
      else $error("control registers not reset");

   wrap16_a: assert property (
      !split && low_wrap && ovh_set
      |=> high_q == ECC_CNT_ZERO && low_q == ECC_CNT_ZERO
          && csr_q.high_overflow_flag)
      else $error("16-bit wrap wrong");

   gate_hold_a: assert property (
      !gate_ok && csr_q.low_reset_release && !csr_wr |=> $stable(low_q))
      else $error("counter moved while gate low");

   wrap16_c:  cover property (!split && ovh_set);
   split_c:   cover property (ovl_set);
   clear_c:   cover property ($fell(csr_q.high_overflow_flag));
   irq_c:     cover property ($rose(irq));

endmodule
`default_nettype wire

// *** ecc_pkg.sv ***
// Contract
// - High select 00 pin, 10 /4, 11 /8
// - Low select: pin, /2, /4, /8
// - PWM prescale /2../16, 1X0 /32, 1X1 /64
// - Reserved bits read/write, reset zero, unused
// - High wrap sets high overflow flag
// - Low wrap flags only in split mode
// - Flag clears by write 0 after read 1
// - Writing one to flags does nothing
// - Split bit 0 chains, 1 separates counters
// - High count enable 0 holds high counter
// - Low count enable 0 holds low counter
// - High release 0 holds high in reset
// - Low release 0 holds low in reset
// - Both control registers reset to zero
// - 16-bit wrap to zero sets high flag
// - Count only while a gate is high
package ecc_pkg;

   // ----------------------------------------
   // Bus map
   // ----------------------------------------
   localparam int          ECC_AW           = 8;
   localparam logic [7:0]  ECC_ADDR_CLKCTL  = 8'h00;
   localparam logic [7:0]  ECC_ADDR_CSR     = 8'h04;
   localparam logic [7:0]  ECC_ADDR_COUNT   = 8'h08;
   localparam logic [7:0]  ECC_ADDR_ISTAT   = 8'h0C;
   localparam logic [7:0]  ECC_ADDR_IMASK   = 8'h10;
   localparam logic [7:0]  ECC_REG_RESET    = 8'h00;
   localparam logic [1:0]  ECC_IRQ_RESET    = 2'h0;

   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [1:0]  ECC_SEL_PIN      = 2'h0;
   localparam logic [1:0]  ECC_SEL_DIV2     = 2'h1;
   localparam logic [1:0]  ECC_SEL_DIV4     = 2'h2;
   localparam logic [1:0]  ECC_SEL_DIV8     = 2'h3;
   localparam logic [7:0]  ECC_CNT_MAX      = 8'hFF;
   localparam logic [7:0]  ECC_CNT_ZERO     = 8'h00;
   localparam int          ECC_PRESC_W      = 6;
   localparam int          ECC_IRQ_HIGH     = 0;
   localparam int          ECC_IRQ_LOW      = 1;
   localparam int          ECC_FLAG_HIGH    = 7;
   localparam int          ECC_FLAG_LOW     = 6;
   localparam int          ECC_RSVD_CSR     = 5;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] high_clock_select;
      logic [1:0] low_clock_select;
      logic [2:0] pwm_prescale;
      logic       reserved;
   } ecc_clk_ctrl_t;

   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic reserved;
      logic channel_split_mode;
      logic high_count_enable;
      logic low_count_enable;
      logic high_reset_release;
      logic low_reset_release;
   } ecc_csr_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ECC_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } ecc_apb_req_t;

endpackage

// *** ecc_event_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecc_event_src (
   input  wire logic sys_clk,   // System clock
   output var  logic high_pin,  // High event line
   output var  logic low_pin,   // Low event line
   output var  logic gate       // External gate level
);
   initial begin
      high_pin = 1'b0;
      low_pin  = 1'b0;
      gate     = 1'b0;
   end

   // ----------------------------------------
   // Event generation
   // ----------------------------------------
   // Three cycles high and three low keep each event wider than the
   // two-stage synchroniser, so no edge is lost
   task automatic pulse(input logic hi, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         high_pin <= hi;
         low_pin  <= !hi;
         repeat (3) @(posedge sys_clk);
         high_pin <= 1'b0;
         low_pin  <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask

   task automatic set_gate(input logic g);
      @(posedge sys_clk);
      gate <= g;
   endtask
endmodule
`default_nettype wire

// *** ecc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecc_top_bench;
   import ecc_pkg::*;

   // ----------------------------------------
   // Clock, reset and wiring
   // ----------------------------------------
   logic          sys_clk        = 1'b0;
   logic          srst           = 1'b1;
   ecc_apb_req_t  apb_req        = '0;
   logic          pwm_count_gate = 1'b0;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic          pwm_clock_tick;
   logic          irq;
   wire logic     high_event_pin;
   wire logic     low_event_pin;
   wire logic     external_count_gate;
   int            err_count      = 0;
   int            checks_done    = 0;
   int            cycles         = 0;
   logic [31:0]   rd;
   logic          err;
   logic [15:0]   d;
   logic [15:0]   f;

   always #12.5 sys_clk = ~sys_clk;

   ecc_top u_dut (
      .sys_clk(sys_clk), .srst(srst), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .high_event_pin(high_event_pin),
      .low_event_pin(low_event_pin), .external_count_gate(external_count_gate),
      .pwm_count_gate(pwm_count_gate), .pwm_clock_tick(pwm_clock_tick), .irq(irq)
   );

   ecc_event_src u_src (
      .sys_clk(sys_clk), .high_pin(high_event_pin), .low_pin(low_event_pin),
      .gate(external_count_gate)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q, output logic e);
      @(posedge sys_clk);
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= wr;
      apb_req.paddr   <= a;
      apb_req.pwdata  <= wd;
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      // The wait ends on the first clock with pready high; the bench timeout catches a hang
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, rd, err);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, '0, rd, err);
      chk(what, exp, rd);
   endtask

   // Read spacing is idle + 3 cycles, a multiple of every divider in use
   task automatic gap(input int idle, output logic [15:0] dd, output logic [15:0] ff);
      logic [31:0] a;
      apb(1'b0, ECC_ADDR_COUNT, '0, a, err);
      repeat (idle) @(posedge sys_clk);
      apb(1'b0, ECC_ADDR_COUNT, '0, rd, err);
      dd = {rd[15:8] - a[15:8], rd[7:0] - a[7:0]};
      ff = rd[15:0] - a[15:0];
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      for (int a = 0; a < 5; a++) rdchk(8'(a * 4), 32'h0, "reset value");
      chk("irq idle", 32'h0, 32'(irq));
      wr(ECC_ADDR_CLKCTL, 32'hFE);
      rdchk(ECC_ADDR_CLKCTL, 32'hFE, "clock control");
      wr(ECC_ADDR_CSR, 32'h1F);
      rdchk(ECC_ADDR_CSR, 32'h1F, "control status");
      wr(ECC_ADDR_CSR, 32'h00);
      apb(1'b0, 8'h14, '0, rd, err);
      chk("unmapped error", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
   endtask

   task automatic t_pwm();
      int n;
      int k;
      for (int c = 0; c < 8; c++) begin
         wr(ECC_ADDR_CLKCTL, 32'(c) << 1);
         repeat (4) @(negedge sys_clk);
         n = 0;
         repeat (128) begin
            @(negedge sys_clk);
            n += int'(pwm_clock_tick === 1'b1);
         end
         k = c[2] ? (c[0] ? 6 : 5) : c + 1;
         chk("pwm ticks", 32'(128 >> k), 32'(n));
      end
   endtask

   task automatic t_rate();
      @(posedge sys_clk);
      pwm_count_gate <= 1'b1;
      wr(ECC_ADDR_CSR, 32'h1F);
      for (int s = 1; s < 4; s++) begin
         wr(ECC_ADDR_CLKCTL, 32'(s * 8'h50));
         gap(61, d, f);
         chk("low rate", 32'(64 >> s), 32'(d[7:0]));
         chk("high rate", 32'(64 >> s), 32'(d[15:8]));
      end
      wr(ECC_ADDR_CLKCTL, 32'h00);
      apb(1'b0, ECC_ADDR_COUNT, '0, rd, err);
      u_src.pulse(1'b1, 5);
      u_src.pulse(1'b0, 3);
      repeat (8) @(posedge sys_clk);
      gap(0, d, f);
      chk("idle pins", 32'h0, 32'(f));
   endtask

   task automatic t_pins();
      logic [31:0] a;
      apb(1'b0, ECC_ADDR_COUNT, '0, a, err);
      u_src.pulse(1'b1, 5);
      u_src.pulse(1'b0, 3);
      repeat (8) @(posedge sys_clk);
      apb(1'b0, ECC_ADDR_COUNT, '0, rd, err);
      chk("high pin events", 32'h5, 32'(rd[15:8] - a[15:8]));
      chk("low pin events", 32'h3, 32'(rd[7:0] - a[7:0]));
   endtask

   task automatic t_hold();
      wr(ECC_ADDR_CLKCTL, 32'h50);
      wr(ECC_ADDR_CSR, 32'h13);
      gap(61, d, f);
      chk("disabled counts", 32'h0, 32'(d));
      wr(ECC_ADDR_CSR, 32'h1F);
      @(posedge sys_clk);
      pwm_count_gate <= 1'b0;
      gap(61, d, f);
      chk("gated counts", 32'h0, 32'(d));
      u_src.set_gate(1'b1);
      // Let the gate clear the synchroniser so the window sees it all the way
      repeat (3) @(posedge sys_clk);
      gap(61, d, f);
      chk("external gate counts", 32'h2020, 32'(d));
      wr(ECC_ADDR_CSR, 32'h1E);
      gap(61, d, f);
      chk("low held high runs", 32'h2000, 32'(d));
      wr(ECC_ADDR_CSR, 32'h1C);
      rdchk(ECC_ADDR_COUNT, 32'h0, "both held");
   endtask

   task automatic t_chain();
      wr(ECC_ADDR_CSR, 32'h0C);
      wr(ECC_ADDR_CSR, 32'h0F);
      wr(ECC_ADDR_CLKCTL, 32'h10);
      gap(1021, d, f);
      chk("chained count", 32'h200, 32'(f));
      rdchk(ECC_ADDR_CSR, 32'h0F, "no flags when chained");
   endtask

   task automatic t_ovf();
      wr(ECC_ADDR_CSR, 32'h1C);
      wr(ECC_ADDR_CLKCTL, 32'h50);
      wr(ECC_ADDR_CSR, 32'h1F);
      repeat (600) @(posedge sys_clk);
      rdchk(ECC_ADDR_ISTAT, 32'h3, "overflow events");
      chk("irq masked", 32'h0, 32'(irq));
      wr(ECC_ADDR_IMASK, 32'h1);
      @(negedge sys_clk);
      chk("irq unmasked", 32'h1, 32'(irq));
      // Writing zero before any read of the flags must not clear them
      wr(ECC_ADDR_CSR, 32'h13);
      rdchk(ECC_ADDR_CSR, 32'hD3, "flags kept");
      wr(ECC_ADDR_CSR, 32'h93);
      rdchk(ECC_ADDR_CSR, 32'h93, "low flag cleared");
      wr(ECC_ADDR_CSR, 32'h13);
      rdchk(ECC_ADDR_CSR, 32'h13, "high flag cleared");
      wr(ECC_ADDR_CSR, 32'hD3);
      rdchk(ECC_ADDR_CSR, 32'h13, "flags not settable");
      wr(ECC_ADDR_ISTAT, 32'h1);
      @(negedge sys_clk);
      chk("irq after clear", 32'h0, 32'(irq));
      rdchk(ECC_ADDR_ISTAT, 32'h2, "event left");
   endtask

   // ----------------------------------------
   // Main sequence and timeout
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_pwm();
      t_rate();
      t_pins();
      t_hold();
      t_chain();
      t_ovf();
      summarize();
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         err_count++;
         summarize();
      end
   end
endmodule
`default_nettype wire
